// >>> hw/mfb_motion.sv
/*
 * Walking test control, status LED and five motion function blocks with telegram outputs.
 * Assumes synchronous inputs, Wishbone master on clk_sys, and arst_n driven on bus supply loss.
 */
// Implementation choices: the register offsets and register access over Wishbone.
// What this block does
// - remote test button toggles walk test if remote and button option enabled
// - remote test button also ends a walk test started after programming
// - remote walk test end returns active blocks to idle, sending end telegrams except from a coupled block
// - bus supply loss resets the device and ends the walk test
// - led shows motion in walk test, and in normal operation if chosen
// - led motion combines all sectors, ignoring brightness and block assignment
// - five independent blocks, each ceiling, presence or detector
// - only the first block may couple to internal light control
// - each block drives two output objects of configured format
// - block works only when enabled; first block always enabled
// - ceiling mode sends begin telegram only below twilight level
// - begin telegram optionally waits a configured evaluation delay
// - ceiling mode ignores brightness after begin telegram for that detection
// - end telegram after motion stops and base 10 s plus added delay
// - output switchable manually regardless of motion, enable or bus return
// - brightness independent twilight level triggers on every motion
// - twilight level configurable, teachable or preset over the bus
// - presence mode keeps comparing brightness while lighting is on
// - presence above switch-off level: stop motion, end after delay
// - between twilight and switch-off levels new motion sends no switch-on
// - during walk test blocks are not processed and send nothing
// - during walk test led follows combined sector motion exactly
`timescale 1ns/100ps
module mfb_motion
	import mfb_pkg::*;
#(
	parameter int TICK_CYC_P = TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire mfb_wb_req_t wb,
	output logic wb_ack,
	output logic [31:0] wb_dat_r,
	input wire logic [NS-1:0] sector,
	input wire logic [15:0] bright,
	input wire logic ir_test,
	input wire logic prog_done,
	input wire logic [NB-1:0] man_on,
	input wire logic [NB-1:0] man_off,
	output logic led_status,
	output mfb_tg_t tg,
	output logic [NB-1:0] obj1_sw,
	output logic [NB*8-1:0] obj2_val,
	output logic lc_presence
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input int b, input logic [7:0] o);
		return a == 8'(int'(BLK_BASE) + b * int'(BLK_STRIDE) + int'(o));
	endfunction

	function automatic logic [31:0] wmask(input logic [31:0] q, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = q;
		for (int k = 0; k < 4; k++) begin
			if (s[k]) begin
				r[k*8 +: 8] = d[k*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] cfg_reg [NB];
	logic [31:0] lvl_reg [NB];
	logic [31:0] val_reg [NB];
	logic [31:0] rd_mux;
	logic [31:0] stat_w;
	logic walk_reg;
	logic led_reg;
	logic [NB-1:0] sw_v;
	logic [NB-1:0] beg_v;
	logic [NB-1:0] end_v;

	wire wb_go = wb.cyc & wb.stb & ~ack_reg;
	wire wb_wr = wb_go & wb.we;
	wire ctrl_hit = wb.adr == CTRL_OFS;
	wire stat_hit = wb.adr == STAT_OFS;

	assign stat_w = {25'h0, led_reg, sw_v, walk_reg};
	assign wb_ack = ack_reg;
	assign wb_dat_r = rdat_reg;

	// unmapped addresses answer with zero and ignore writes
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (ctrl_hit) begin
			rd_mux = ctrl_reg;
		end
		if (stat_hit) begin
			rd_mux = stat_w;
		end
		for (int i = 0; i < NB; i++) begin
			if (hit(wb.adr, i, CFG_OFS)) begin
				rd_mux = cfg_reg[i];
			end
			if (hit(wb.adr, i, LVL_OFS)) begin
				rd_mux = lvl_reg[i];
			end
			if (hit(wb.adr, i, VAL_OFS)) begin
				rd_mux = val_reg[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
			ctrl_reg <= CTRL_RST;
		end else begin
			ack_reg <= wb_go;
			if (wb_go) begin
				rdat_reg <= rd_mux;
			end
			if (wb_wr && ctrl_hit) begin
				ctrl_reg <= wmask(ctrl_reg, wb.dat, wb.sel);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NB; i++) begin
				cfg_reg[i] <= CFG_RST;
				lvl_reg[i] <= LVL_RST;
				val_reg[i] <= VAL_RST;
			end
		end else begin
			for (int i = 0; i < NB; i++) begin
				if (wb_wr && hit(wb.adr, i, CFG_OFS)) begin
					cfg_reg[i] <= wmask(cfg_reg[i], wb.dat, wb.sel);
				end
				if (wb_wr && hit(wb.adr, i, TEACH_OFS)) begin
					lvl_reg[i] <= {lvl_reg[i][31:16], bright};
				end else if (wb_wr && hit(wb.adr, i, LVL_OFS)) begin
					lvl_reg[i] <= wmask(lvl_reg[i], wb.dat, wb.sel);
				end
				if (wb_wr && hit(wb.adr, i, VAL_OFS)) begin
					val_reg[i] <= wmask(val_reg[i], wb.dat, wb.sel);
				end
			end
		end
	end

	// ----------------------------------------
	// time base and walking test
	// ----------------------------------------
	logic [24:0] tick_cnt_reg;
	wire tick = tick_cnt_reg == 25'(TICK_CYC_P - 1);
	wire ir_ok = ir_test & ctrl_reg[IR_EN_BIT] & ctrl_reg[TBTN_BIT];
	// remote press ends any walk test
	wire walk_end = walk_reg & ir_ok;
	wire any_mot = |sector;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt_reg <= 25'h0000000;
		end else begin
			tick_cnt_reg <= tick ? 25'h0000000 : tick_cnt_reg + 25'h0000001;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			walk_reg <= 1'b0;
		end else if (ir_ok) begin
			walk_reg <= ~walk_reg;
		end else if (prog_done && ctrl_reg[AUTO_BIT]) begin
			walk_reg <= 1'b1;
		end
	end

	// led in walk test or chosen normal display
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			led_reg <= 1'b0;
		end else begin
			led_reg <= (walk_reg | ctrl_reg[DISP_BIT]) & any_mot;
		end
	end
	assign led_status = led_reg;

	// ----------------------------------------
	// function blocks
	// ----------------------------------------
	// independent block instances
	for (genvar b = 0; b < NB; b++) begin : g_blk
		mfb_st_t st_reg;
		mfb_st_t st_next;
		logic [8:0] cnt_reg;
		logic [8:0] cnt_next;
		logic on_p;
		logic off_p;
		logic beg_reg;
		logic end_reg;
		logic sw_reg;
		logic [7:0] o2_reg;
		wire [31:0] cfg = cfg_reg[b];
		wire [1:0] mode = cfg[MODE_LSB +: 2];
		wire en = (b == 0) | cfg[EN_BIT];
		// coupling only on the first block
		wire lc = (b == 0) & cfg[LC_BIT];
		wire mot = |(sector & cfg[SECT_LSB +: NS]);
		wire indep = cfg[INDEP_BIT] | (mode == MODE_DET);
		wire below = indep | (bright < lvl_reg[b][15:0]);
		wire over = ~indep & (mode == MODE_PRES) & (bright > lvl_reg[b][31:16]);
		wire [7:0] eval = cfg[EVAL_LSB +: 8];
		wire [7:0] offd = cfg[OFFD_LSB +: 8];
		wire [8:0] total = BASE_DELAY_S + {1'b0, cfg[ADD_LSB +: 8]};
		wire [8:0] off_load = (offd != 8'h00) ? {1'b0, offd} : total;
		// delays count whole time-base ticks, so up to one tick of early expiry
		wire expire = tick & (cnt_reg <= 9'h001);
		wire [8:0] cnt_dec = tick ? cnt_reg - 9'h001 : cnt_reg;

		always_comb begin
			st_next = st_reg;
			cnt_next = cnt_reg;
			on_p = 1'b0;
			off_p = 1'b0;
			if (walk_end) begin
				st_next = ST_IDLE;
				cnt_next = 9'h000;
				off_p = st_reg != ST_IDLE;
			end else if (!walk_reg) begin
				if (man_on[b]) begin
					on_p = 1'b1;
				end else if (man_off[b]) begin
					off_p = 1'b1;
				end else if (!en) begin
					st_next = ST_IDLE;
					cnt_next = 9'h000;
				end else begin
					unique case (st_reg)
						ST_IDLE: begin
							if (mot && below) begin
								if (eval == 8'h00) begin
									on_p = 1'b1;
									st_next = ST_ON;
								end else begin
									st_next = ST_EVAL;
									cnt_next = {1'b0, eval};
								end
							end
						end
						ST_EVAL: begin
							if (!mot) begin
								st_next = ST_IDLE;
							end else if (expire) begin
								on_p = 1'b1;
								st_next = ST_ON;
							end else begin
								cnt_next = cnt_dec;
							end
						end
						ST_ON: begin
							if (over) begin
								st_next = ST_SHUT;
								cnt_next = off_load;
							end else if (!mot) begin
								st_next = ST_HOLD;
								cnt_next = total;
							end
						end
						ST_HOLD: begin
							if (over) begin
								st_next = ST_SHUT;
								cnt_next = off_load;
							end else if (mot) begin
								st_next = ST_ON;
							end else if (expire) begin
								off_p = 1'b1;
								st_next = ST_IDLE;
							end else begin
								cnt_next = cnt_dec;
							end
						end
						ST_SHUT: begin
							if (expire) begin
								off_p = 1'b1;
								st_next = ST_IDLE;
							end else begin
								cnt_next = cnt_dec;
							end
						end
					endcase
				end
			end
		end

		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				st_reg <= ST_IDLE;
				cnt_reg <= 9'h000;
				beg_reg <= 1'b0;
				end_reg <= 1'b0;
				sw_reg <= 1'b0;
				o2_reg <= 8'h00;
			end else begin
				st_reg <= st_next;
				cnt_reg <= cnt_next;
				// coupled block talks to light control, not to the bus
				beg_reg <= on_p & ~lc;
				end_reg <= off_p & ~lc;
				if (on_p) begin
					sw_reg <= 1'b1;
					o2_reg <= val_reg[b][7:0];
				end else if (off_p) begin
					sw_reg <= 1'b0;
					o2_reg <= val_reg[b][15:8];
				end
			end
		end

		assign sw_v[b] = sw_reg;
		assign beg_v[b] = beg_reg;
		assign end_v[b] = end_reg;
		assign obj2_val[b*8 +: 8] = o2_reg;

		walk_exit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
			walk_end && st_reg != ST_IDLE && !lc |=> end_reg && st_reg == ST_IDLE)
			else $error("active block not reset at walk test end");
		walk_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
			walk_reg && !walk_end |=> !beg_reg && !end_reg && $stable(st_reg))
			else $error("block active during walk test");
		dark_only_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
			st_reg == ST_IDLE && !walk_reg && !man_on[b] && en && !below |=> !beg_reg)
			else $error("begin telegram sent while bright");
		hold_retrig_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
			st_reg == ST_HOLD && mot && !over && en && !walk_reg && !man_on[b]
			&& !man_off[b] |=> st_reg == ST_ON)
			else $error("motion did not restart delay");
		disabled_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
			!en && !man_on[b] |=> !beg_reg)
			else $error("disabled block sent begin");
		manual_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
			man_on[b] && !walk_reg |=> sw_reg ##0 (beg_reg == !lc))
			else $error("manual switch-on not applied");
		shut_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
			st_reg == ST_ON && over && en && !walk_reg && !man_on[b] && !man_off[b]
			|=> st_reg == ST_SHUT && cnt_reg == $past(off_load))
			else $error("switch-off level not honoured");
		c_begin: cover property (@(posedge clk_sys) disable iff (!arst_n) beg_reg);
		c_end: cover property (@(posedge clk_sys) disable iff (!arst_n) end_reg);
	end

	assign tg.begin_p = beg_v;
	assign tg.end_p = end_v;
	assign obj1_sw = sw_v;
	assign lc_presence = cfg_reg[0][LC_BIT] & sw_v[0];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	walk_toggle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ir_ok |=> walk_reg != $past(walk_reg))
		else $error("walk test not toggled by remote");
	walk_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!ir_ok && !prog_done |=> walk_reg == $past(walk_reg))
		else $error("walk test changed without cause");
	led_walk_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		walk_reg |=> led_status == $past(any_mot))
		else $error("led does not follow motion in walk test");
	led_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!walk_reg && !ctrl_reg[DISP_BIT] |=> !led_status)
		else $error("led lit in normal operation without option");
	wb_ack_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wb.cyc && wb.stb && !wb_ack |=> wb_ack ##1 !wb_ack)
		else $error("bus answer not one cycle");
	c_walk_on: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(walk_reg));
	c_walk_off: cover property (@(posedge clk_sys) disable iff (!arst_n) walk_end);
	c_led: cover property (@(posedge clk_sys) disable iff (!arst_n) led_status && !walk_reg);
endmodule

// >>> hw/mfb_pkg.sv
/*
 * Shared constants and types for the motion function block and walking test logic.
 * Assumes a 20 MHz system clock and a 32-bit classic Wishbone register port.
 */
package mfb_pkg;
	// ----------------------------------------
	// sizes and timing
	// ----------------------------------------
	localparam int NB = 5;
	localparam int NS = 3;
	localparam int CLK_HZ = 20_000_000;
	localparam int TIME_BASE_MS = 1000;
	localparam int TICK_CYC = CLK_HZ / 1000 * TIME_BASE_MS;
	localparam logic [8:0] BASE_DELAY_S = 9'h00a;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] BLK_BASE = 8'h10;
	localparam logic [7:0] BLK_STRIDE = 8'h10;
	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] LVL_OFS = 8'h04;
	localparam logic [7:0] VAL_OFS = 8'h08;
	localparam logic [7:0] TEACH_OFS = 8'h0c;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int IR_EN_BIT = 0;
	localparam int TBTN_BIT = 1;
	localparam int DISP_BIT = 2;
	localparam int AUTO_BIT = 3;
	localparam int EN_BIT = 0;
	localparam int MODE_LSB = 1;
	localparam int INDEP_BIT = 3;
	localparam int LC_BIT = 4;
	localparam int SECT_LSB = 5;
	localparam int EVAL_LSB = 8;
	localparam int ADD_LSB = 16;
	localparam int OFFD_LSB = 24;
	localparam logic [1:0] MODE_CEIL = 2'h0;
	localparam logic [1:0] MODE_PRES = 2'h1;
	localparam logic [1:0] MODE_DET = 2'h2;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CFG_RST = 32'h0000_00e1;
	localparam logic [31:0] LVL_RST = 32'h0400_0100;
	localparam logic [31:0] VAL_RST = 32'h0000_0001;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_EVAL, ST_ON, ST_HOLD, ST_SHUT} mfb_st_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} mfb_wb_req_t;
	typedef struct packed {
		logic [NB-1:0] begin_p;
		logic [NB-1:0] end_p;
	} mfb_tg_t;
endpackage

// >>> verif/mfb_actuator.sv
/*
 * Bus actuator model: counts begin and end telegrams per block and keeps the switched state.
 * Assumes telegram pulses are one clk_sys cycle wide and sampled on the rising edge;
 * a held arst_n clears the counts so that every scenario starts from zero.
 */
`timescale 1ns/100ps
module mfb_actuator
	import mfb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire mfb_tg_t tg
);
	int begin_cnt [NB];
	int end_cnt [NB];
	logic [NB-1:0] lit;
	// ----------------------------------------
	// telegram reception
	// ----------------------------------------
	// output object state
	always @(posedge clk_sys) begin
		for (int b = 0; b < NB; b++) begin
			if (!arst_n) begin
				begin_cnt[b] = 0;
				end_cnt[b] = 0;
				lit[b] <= 1'b0;
			end else begin
				if (tg.begin_p[b] === 1'b1) begin
					begin_cnt[b]++;
					lit[b] <= 1'b1;
				end
				if (tg.end_p[b] === 1'b1) begin
					end_cnt[b]++;
					lit[b] <= 1'b0;
				end
			end
		end
	end
endmodule

// >>> verif/test_mfb_motion.sv
/*
 * Self-checking bench for the motion blocks, walking test and status led.
 * Assumes a shortened one-second tick of TK cycles and the actuator model on the telegrams.
 */
`timescale 1ns/100ps
module test_mfb_motion;
	import mfb_pkg::*;
	localparam int TK = 20;
	logic clk_sys, arst_n, wb_ack, ir_test, prog_done, led_status, lc_presence;
	mfb_wb_req_t wb;
	logic [31:0] wb_dat_r, rd;
	logic [NS-1:0] sector;
	logic [15:0] bright;
	logic [NB-1:0] man_on, man_off, obj1_sw;
	logic [NB*8-1:0] obj2_val;
	mfb_tg_t tg;
	int bad_count, compares, b0;
	mfb_motion #(.TICK_CYC_P(TK)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb(wb),
		.wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .sector(sector), .bright(bright),
		.ir_test(ir_test), .prog_done(prog_done), .man_on(man_on), .man_off(man_off),
		.led_status(led_status), .tg(tg), .obj1_sw(obj1_sw), .obj2_val(obj2_val),
		.lc_presence(lc_presence));
	mfb_actuator act (.clk_sys(clk_sys), .arst_n(arst_n), .tg(tg));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// single classic cycle; ack is looked at on each rising edge only
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n = 0;
		@(posedge clk_sys);
		wb <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		rd = wb_dat_r;
		wb <= '0;
		if (n == 50) chk(32'h0, 32'h1, "no ack");
	endtask
	function automatic logic [7:0] badr(input int b, input logic [7:0] ofs);
		return BLK_BASE + BLK_STRIDE * 8'(b) + ofs;
	endfunction
	task automatic do_reset();
		@(posedge clk_sys);
		arst_n <= 1'b0;
		tick(16);
		arst_n <= 1'b1;
	endtask
	task automatic motion(input logic [2:0] s, input int n);
		@(posedge clk_sys);
		sector <= s;
		tick(n);
		sector <= '0;
	endtask
	task automatic ir_press();
		@(posedge clk_sys);
		ir_test <= 1'b1;
		@(posedge clk_sys);
		ir_test <= 1'b0;
		tick(2);
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		do_reset();
		bus(1'b0, badr(0, CFG_OFS), 32'h0);
		chk(rd, CFG_RST, "cfg0 reset");
		bus(1'b0, badr(0, LVL_OFS), 32'h0);
		chk(rd, LVL_RST, "lvl0 reset");
		bus(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0, "unmapped");
		bright <= 16'h1234;
		bus(1'b1, badr(1, TEACH_OFS), 32'h0);
		bus(1'b0, badr(1, LVL_OFS), 32'h0);
		chk(rd, {LVL_RST[31:16], 16'h1234}, "teach level");
	endtask
	task automatic t_ceiling();
		do_reset();
		bright <= 16'h0200;
		motion(3'h1, 2);
		tick(4);
		chk(act.begin_cnt[0], 0, "bright begin");
		bright <= 16'h0050;
		motion(3'h1, 2);
		tick(3);
		chk(act.begin_cnt[0], 1, "dark begin");
		chk(obj1_sw[0], 1'b1, "obj1 on");
		chk(act.lit[0], 1'b1, "actuator on");
		// brightness rises but the running detection must not end early
		bright <= 16'hffff;
		tick(5 * TK);
		motion(3'h2, 1);
		tick(8 * TK);
		chk(act.end_cnt[0], 0, "end early");
		tick(3 * TK);
		chk(act.end_cnt[0], 1, "end after total");
		chk(act.lit[0], 1'b0, "actuator off");
	endtask
	task automatic t_indep();
		do_reset();
		bus(1'b1, badr(0, CFG_OFS), CFG_RST | 32'h8);
		bus(1'b1, badr(2, CFG_OFS), CFG_RST & 32'hffff_fffe);
		bright <= 16'hffff;
		motion(3'h4, 2);
		tick(3);
		chk(act.begin_cnt[0], 1, "indep begin");
		chk(act.begin_cnt[2], 0, "disabled block");
		@(posedge clk_sys);
		man_on <= 5'h04;
		@(posedge clk_sys);
		man_on <= '0;
		tick(2);
		chk(act.begin_cnt[2], 1, "manual on");
		chk(obj2_val[23:16], VAL_RST[7:0], "obj2 begin value");
		@(posedge clk_sys);
		man_off <= 5'h04;
		@(posedge clk_sys);
		man_off <= '0;
		tick(2);
		chk(act.end_cnt[2], 1, "manual off");
		chk(obj2_val[23:16], VAL_RST[15:8], "obj2 end value");
		// block 0 is still holding from the motion above; couple it now
		bus(1'b1, badr(0, CFG_OFS), CFG_RST | 32'h18);
		chk(lc_presence, 1'b1, "presence to light control");
		tick(12 * TK);
		chk(lc_presence, 1'b0, "presence released");
		chk(act.end_cnt[0], 0, "coupled block silent");
	endtask
	task automatic t_pres();
		do_reset();
		bus(1'b1, badr(0, CFG_OFS), 32'h0300_02e3);
		bright <= 16'h0050;
		@(posedge clk_sys);
		sector <= 3'h1;
		tick(3);
		chk(act.begin_cnt[0], 0, "eval hold");
		tick(3 * TK);
		chk(act.begin_cnt[0], 1, "eval begin");
		bright <= 16'h0800;
		tick(2);
		chk(act.end_cnt[0], 0, "switch-off delay");
		tick(4 * TK);
		chk(act.end_cnt[0], 1, "switch-off end");
		sector <= '0;
		bright <= 16'h0200;
		motion(3'h1, 2);
		tick(3);
		chk(act.begin_cnt[0], 1, "between levels");
	endtask
	task automatic t_walk();
		do_reset();
		ir_press();
		bus(1'b0, STAT_OFS, 32'h0);
		chk(rd[0], 1'b0, "ir refused");
		bus(1'b1, CTRL_OFS, 32'h3);
		bright <= 16'h0050;
		motion(3'h1, 2);
		tick(3);
		b0 = act.begin_cnt[0];
		ir_press();
		bus(1'b0, STAT_OFS, 32'h0);
		chk(rd[0], 1'b1, "walk on");
		@(posedge clk_sys);
		sector <= 3'h4;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(led_status, 1'b1, "led on");
		@(posedge clk_sys);
		sector <= '0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(led_status, 1'b0, "led off");
		tick(12 * TK);
		chk(act.begin_cnt[0] + act.end_cnt[0], b0, "walk quiet");
		ir_press();
		chk(act.end_cnt[0], 1, "walk end");
		bus(1'b1, CTRL_OFS, 32'h3);
		bright <= 16'hffff;
		motion(3'h2, 2);
		@(negedge clk_sys);
		chk(led_status, 1'b0, "led normal off");
		bus(1'b1, CTRL_OFS, 32'h7);
		@(posedge clk_sys);
		sector <= 3'h2;
		tick(2);
		@(negedge clk_sys);
		chk(led_status, 1'b1, "led normal on");
		@(posedge clk_sys);
		sector <= '0;
	endtask
	task automatic t_auto();
		do_reset();
		bus(1'b1, CTRL_OFS, 32'hb);
		@(posedge clk_sys);
		prog_done <= 1'b1;
		@(posedge clk_sys);
		prog_done <= 1'b0;
		bus(1'b0, STAT_OFS, 32'h0);
		chk(rd[0], 1'b1, "auto walk on");
		ir_press();
		bus(1'b0, STAT_OFS, 32'h0);
		chk(rd[0], 1'b0, "auto walk ended");
		ir_press();
		do_reset();
		bus(1'b0, STAT_OFS, 32'h0);
		chk(rd[0], 1'b0, "walk after reset");
	endtask
	// ----------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		tick(40000);
		bad_count++;
		print_verdict();
	end
	initial begin
		bad_count = 0;
		compares = 0;
		arst_n = 1'b0;
		wb = '0;
		sector = '0;
		bright = 16'h0;
		ir_test = 1'b0;
		prog_done = 1'b0;
		man_on = '0;
		man_off = '0;
		t_regs();
		t_ceiling();
		t_indep();
		t_pres();
		t_walk();
		t_auto();
		print_verdict();
	end
endmodule
